// ==== dv/host_bus_model.sv ====
/*
  Processor bus model: issues one memory transaction at a time.
  Assumes the decoder takes a transaction at the edge where valid is high.
*/
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
  import decoder_pkg::*;
(
  input  wire logic   clk_in,
  output logic        txn_valid_out,
  output var txn_type txn_out
);
  // Idle bus at time zero
  initial begin
    txn_valid_out = 1'b0;
    txn_out = '0;
  end

  // Hold the request for one taking edge, then scramble the released bus
  task automatic issue(input logic [35:0] a, input logic w, input logic s);
    @(posedge clk_in);
    txn_valid_out <= 1'b1;
    txn_out <= {a, w, s};
    @(posedge clk_in);
    txn_valid_out <= 1'b0;
    txn_out <= {~a, ~w, ~s};
  endtask
endmodule // host_bus_model

`default_nettype wire

// ==== dv/tb_top.sv ====
/*
  Self-checking testbench of the host memory address decoder.
  Assumes decoder_pkg and host_bus_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import decoder_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        ce_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_we_in = 1'b0;
  logic        reg_re_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic        txn_valid_in;
  txn_type     txn_in;
  logic        route_valid_out;
  route_type   route_out;
  logic [31:0] rv;
  int          n_fail = 0;
  int          checks_done = 0;

  // Clock of 4 ns
  always #2 clk_in = ~clk_in;

  host_bus_model u_host (.clk_in(clk_in), .txn_valid_out(txn_valid_in), .txn_out(txn_in));

  host_memory_address_decoder dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_we_in(reg_we_in), .reg_re_in(reg_re_in),
    .reg_rdata_out(reg_rdata_out), .txn_valid_in(txn_valid_in), .txn_in(txn_in),
    .route_valid_out(route_valid_out), .route_out(route_out));

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_we_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_we_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_re_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_re_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  // One transaction, judged 1 ns after the taking edge
  task automatic rt(input logic [35:0] a, input logic w, input logic s,
                    input target_type t, input logic [35:0] d);
    u_host.issue(a, w, s);
    #1;
    chk("route valid", 36'(route_valid_out), 36'h1);
    chk("route target", 36'(route_out.target), 36'(t));
    if (t == TGT_DRAM)
      chk("dram address", route_out.dram_addr, d);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    #1;
    chk("route valid idle", 36'(route_valid_out), 36'h0);
    rd(8'h00, rv);
    chk("ctrl reset", 36'(rv), 36'h0);
    rd(8'h04, rv);
    chk("attr reset", 36'(rv), 36'h0);
    rd(8'h08, rv);
    chk("low top reset", 36'(rv), 36'h1000);
    rd(8'h0c, rv);
    chk("dram top reset", 36'(rv), 36'h1000);
    rd(8'h10, rv);
    chk("status reset", 36'(rv), 36'h0);
    rd(8'h14, rv);
    chk("unmapped read", 36'(rv), 36'h0);
  endtask

  task automatic t_low();
    rt(36'h0, 1'b0, 1'b0, TGT_DRAM, 36'h0);
    rt(36'h7ffff, 1'b1, 1'b0, TGT_DRAM, 36'h7ffff);
    rt(36'h80000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    wr(8'h00, 32'h1);
    rt(36'h80000, 1'b0, 1'b0, TGT_DRAM, 36'h80000);
    rt(36'h9ffff, 1'b1, 1'b0, TGT_DRAM, 36'h9ffff);
    rt(36'ha0000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'hbffff, 1'b1, 1'b0, TGT_PCI, 36'h0);
    rt(36'hf0000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'hfffff, 1'b1, 1'b0, TGT_PCI, 36'h0);
    @(posedge clk_in);
    #1;
    chk("route pulse", 36'(route_valid_out), 36'h0);
  endtask

  // one segment programmed at a time
  task automatic t_attr();
    logic [35:0] lo;
    logic [35:0] hi;
    for (int i = 0; i < 13; i++) begin
      lo = (i < 12) ? 36'hc0000 + 36'(i) * 36'h4000 : 36'hf0000;
      hi = lo + ((i < 12) ? 36'h3fff : 36'hffff);
      wr(8'h04, 32'h1 << (2 * i));
      rt(lo, 1'b0, 1'b0, TGT_DRAM, lo);
      rt(hi, 1'b1, 1'b0, TGT_PCI, 36'h0);
      wr(8'h04, 32'h2 << (2 * i));
      rt(hi, 1'b0, 1'b0, TGT_PCI, 36'h0);
      rt(lo, 1'b1, 1'b0, TGT_DRAM, lo);
      if (i < 12)
        rt(hi + 36'h1, 1'b1, 1'b0, TGT_PCI, 36'h0);
    end
    wr(8'h04, 32'h0);
  endtask

  task automatic t_ext();
    wr(8'h08, 32'h0800);
    wr(8'h0c, 32'h1000);
    rt(36'hffffff, 1'b0, 1'b0, TGT_DRAM, 36'hffffff);
    wr(8'h00, 32'h2);
    rt(36'hf00000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'hffffff, 1'b1, 1'b0, TGT_PCI, 36'h0);
    rt(36'h1000000, 1'b0, 1'b0, TGT_DRAM, 36'h1000000);
    rt(36'h7ffffff, 1'b0, 1'b0, TGT_DRAM, 36'h7ffffff);
    rt(36'h8000000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'hfec00000, 1'b0, 1'b0, TGT_IOAPIC, 36'h0);
    rt(36'hfec0ffff, 1'b1, 1'b0, TGT_IOAPIC, 36'h0);
    rt(36'hfec10000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'hfff00000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'hffffffff, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'h100000000, 1'b0, 1'b0, TGT_DRAM, 36'h8000000);
    rt(36'h107ffffff, 1'b1, 1'b0, TGT_DRAM, 36'hfffffff);
    rt(36'h108000000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    // Status: 87 transactions so far, last one to PCI, no segments
    rd(8'h10, rv);
    chk("status count", 36'(rv), 36'h0_0057_0010);
  endtask

  // every row of the enable table
  task automatic t_smm();
    logic g;
    logic h;
    logic t;
    for (int k = 0; k < 8; k++) begin
      {t, h, g} = 3'(k);
      wr(8'h00, {27'h0, t, h, g, 2'h0});
      rd(8'h10, rv);
      chk("segments active", 36'(rv[2:0]), {33'h0, g & ~h, g & h, g & t});
      rt(36'ha0000, 1'b0, 1'b1, (g & ~h) ? TGT_DRAM : TGT_PCI, 36'ha0000);
      rt(36'ha0000, 1'b1, 1'b0, TGT_PCI, 36'h0);
      rt(36'hfeda0000, 1'b1, 1'b1, (g & h) ? TGT_DRAM : TGT_PCI, 36'ha0000);
      rt(36'hfedbffff, 1'b0, 1'b1, (g & h) ? TGT_DRAM : TGT_PCI, 36'hbffff);
      rt(36'h7fe0000, 1'b0, 1'b1, TGT_DRAM, 36'h7fe0000);
      rt(36'h7fe0000, 1'b0, 1'b0, (g & t) ? TGT_PCI : TGT_DRAM, 36'h7fe0000);
      rt(36'h7fdffff, 1'b0, 1'b0, TGT_DRAM, 36'h7fdffff);
    end
    wr(8'h00, 32'h24);
    rt(36'ha0000, 1'b0, 1'b0, TGT_DRAM, 36'ha0000);
    // 256 KB, 512 KB and 1 MB top segment edges
    wr(8'h00, 32'h54);
    rt(36'h7fc0000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'h7fbffff, 1'b0, 1'b0, TGT_DRAM, 36'h7fbffff);
    wr(8'h00, 32'h94);
    rt(36'h7f80000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'h7f7ffff, 1'b0, 1'b0, TGT_DRAM, 36'h7f7ffff);
    wr(8'h00, 32'hd4);
    rt(36'h7f00000, 1'b0, 1'b0, TGT_PCI, 36'h0);
    rt(36'h7efffff, 1'b0, 1'b0, TGT_DRAM, 36'h7efffff);
  endtask

  // Clock enable low freezes all state, then a reset in mid-run
  task automatic t_ce();
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(8'h00, 32'h1);
    u_host.issue(36'h0, 1'b0, 1'b0);
    #1;
    chk("frozen route valid", 36'(route_valid_out), 36'h0);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd(8'h00, rv);
    chk("frozen ctrl", 36'(rv), 36'hd4);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(8'h10, rv);
    chk("status after reset", 36'(rv), 36'h0);
    rt(36'hf0000, 1'b0, 1'b0, TGT_PCI, 36'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_low();
    t_attr();
    t_ext();
    t_smm();
    t_ce();
    complete_run();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(60000 * 4);
    n_fail++;
    complete_run();
  end
endmodule // tb_top

`default_nettype wire

// ==== src/decoder_defs.svh ====
/*
  Constants of the host memory address decoder: address map, register
  offsets, field positions and reset values.
  Assumes a 36-bit host address and a 32-bit register port.
*/
`ifndef DECODER_DEFS_SVH
`define DECODER_DEFS_SVH

// Address map
`define ADDR_W     36
`define DOS_END    36'h0_0007_ffff
`define ISA_LO     36'h0_0008_0000
`define ISA_HI     36'h0_0009_ffff
`define VGA_LO     36'h0_000a_0000
`define VGA_HI     36'h0_000b_ffff
`define ATTR_LO    36'h0_000c_0000
`define ATTR_HI    36'h0_000f_ffff
`define MEG1       36'h0_0010_0000
`define HOLE15_LO  36'h0_00f0_0000
`define HOLE15_HI  36'h0_00ff_ffff
`define APIC_LO    36'h0_fec0_0000
`define APIC_HI    36'h0_fec0_ffff
`define HIGH_SMM_SEGMENT_LO    36'h0_feda_0000
`define HIGH_SMM_SEGMENT_HI    36'h0_fedb_ffff
`define HBIOS_LO   36'h0_fff0_0000
`define HBIOS_HI   36'h0_ffff_ffff
`define FOUR_GB    36'h1_0000_0000
`define TOP_SMM_SEGMENT_UNIT  36'h0_0002_0000

// Legacy attribute layout: two bits per segment, read then write
`define ATTR_W     26
`define F_SEG      4'hc
`define ATTR_RD    1'h0
`define ATTR_WR    1'h1
`define F_RD_IDX   5'h18
`define F_WR_IDX   5'h19

// Register offsets
`define REG_AW     8
`define REG_CTRL   8'h00
`define REG_ATTR   8'h04
`define REG_TOP_OF_LOW_DRAM   8'h08
`define REG_TOM    8'h0c
`define REG_STAT   8'h10

// Control fields
`define CTRL_W     8
`define CTRL_ISA   0
`define CTRL_HOLE  1
`define CTRL_GLB   2
`define CTRL_HIGH  3
`define CTRL_TOP   4
`define CTRL_OPEN  5
`define CTRL_TSZ   7:6

// Reset values
`define CTRL_RST   8'h00
`define ATTR_RST   26'h000_0000
`define TOP_OF_LOW_DRAM_RST   16'h1000
`define TOM_RST    20'h0_1000

`endif

// ==== src/decoder_pkg.sv ====
/*
  Types and shared decode function of the host memory address decoder.
  Assumes decoder_defs.svh on the include path.
*/
`include "decoder_defs.svh"

package decoder_pkg;

  typedef enum logic [1:0] {TGT_DRAM, TGT_PCI, TGT_IOAPIC} target_type;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic               write;
    logic               smm;
  } txn_type;

  typedef struct packed {
    target_type         target;
    logic [`ADDR_W-1:0] dram_addr;
  } route_type;

  typedef struct packed {
    logic c;
    logic h;
    logic t;
  } smm_act_type;

  // Inclusive address range test
  function automatic logic in_rng(input logic [`ADDR_W-1:0] x,
                                  input logic [`ADDR_W-1:0] lo,
                                  input logic [`ADDR_W-1:0] hi);
    in_rng = (x >= lo) && (x <= hi);
  endfunction

endpackage

// ==== src/host_memory_address_decoder.sv ====
/*
  Host memory address decoder. Each processor memory transaction gets
  one target (DRAM, PCI or the interrupt-controller block) and, for
  DRAM, the address to use there. Segment attributes, management RAM
  and the low-DRAM split come from registers on a plain register port.
  Assumes one clock, a synchronous active-low reset, a register master
  that never raises both strobes together, and a processor bus on the
  same clock presenting at most one transaction per cycle.
*/
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "decoder_defs.svh"

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Lowest 512 KB routed to DRAM unless a hidden top segment lies there
// - ISA window goes to PCI or DRAM
// - Graphics window goes to PCI by default
// - Eight 16 KB add-in segments with attributes
// - Four 16 KB extended blocks, DRAM or PCI
// - System BIOS block goes to PCI after reset
// - Read and write attributes act independently
// - Read-only shadow sends writes to expansion bus
// - Optional 15 MB hole sent to PCI
// - Above low DRAM, below 4 GB to PCI
// - Top 1 MB below 4 GB is firmware
// - Interrupt-controller 64 KB block never hits DRAM
// - DRAM under the hole reclaimed above 4 GB
// - Management RAM only visible in management or open
// - Compatible segment sends A0000-BFFFF to DRAM
// - High segment translated down to A0000-BFFFF
// - Top segment hits DRAM at same addresses
module host_memory_address_decoder
  import decoder_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rstn_in,
  input  wire logic               ce_in,
  input  wire logic [`REG_AW-1:0] reg_addr_in,
  input  wire logic [31:0]        reg_wdata_in,
  input  wire logic               reg_we_in,
  input  wire logic               reg_re_in,
  output logic [31:0]             reg_rdata_out,
  input  wire logic               txn_valid_in,
  input  wire txn_type            txn_in,
  output logic                    route_valid_out,
  output var  route_type          route_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [`CTRL_W-1:0] ctrl_r;
  logic [`ATTR_W-1:0] attr_r;
  logic [15:0]        top_of_low_dram_r;
  logic [19:0]        tom_r;
  logic [15:0]        count_r;
  target_type         last_tgt_r;
  logic [31:0]        rdata_r;
  logic               route_valid_r;
  route_type          route_r;

  logic [`ADDR_W-1:0] a;
  logic [`ADDR_W-1:0] top_of_low_dram_addr;
  logic [`ADDR_W-1:0] tom_addr;
  logic [`ADDR_W-1:0] gap;
  logic [`ADDR_W:0]   reclaim_top;
  logic [`ADDR_W-1:0] xlate;
  target_type         tgt_nxt;
  route_type          route_nxt;
  logic [31:0]        rd_mux;
  logic [31:0]        stat_word;

  logic               isa_to_dram;
  logic               hole15_en;
  logic               smram_global_enable;
  logic               smram_high_alias_enable;
  logic               top_smm_segment_enable;
  logic               smram_open;
  logic [1:0]         top_smm_segment_size;

  smm_act_type        smm_act;
  logic               c_hit;
  logic               h_hit;
  logic               t_hit;
  logic               visible;
  logic               smm_dram;
  logic               smm_block;
  logic               attr_hit;
  logic               attr_dram;

  logic               dos;
  logic               isa;
  logic               vga;
  logic               hole15;
  logic               apic;
  logic               hbios;
  logic               below_top_of_low_dram;
  logic               above4;
  logic               reclaim;
  logic               wr;
  logic               take;

  ////////////////////////////////////////////////////////////////////////
  // Configuration fields

  assign isa_to_dram             = ctrl_r[`CTRL_ISA];
  assign hole15_en               = ctrl_r[`CTRL_HOLE];
  assign smram_global_enable     = ctrl_r[`CTRL_GLB];
  assign smram_high_alias_enable = ctrl_r[`CTRL_HIGH];
  assign top_smm_segment_enable  = ctrl_r[`CTRL_TOP];
  assign smram_open              = ctrl_r[`CTRL_OPEN];
  assign top_smm_segment_size    = ctrl_r[`CTRL_TSZ];

  // Boundaries held in 64 KB units
  assign top_of_low_dram_addr   = {4'h0, top_of_low_dram_r, 16'h0000};
  assign tom_addr    = {tom_r, 16'h0000};
  assign gap         = `FOUR_GB - top_of_low_dram_addr;
  assign reclaim_top = {1'b0, tom_addr} + {1'b0, gap};

  ////////////////////////////////////////////////////////////////////////
  // Region decode

  assign a    = txn_in.addr;
  assign take = ce_in & txn_valid_in;

  smm_space_decode u_smm (
    .addr_in        (a),
    .top_of_low_dram_addr_in   (top_of_low_dram_addr),
    .global_en_in   (smram_global_enable),
    .high_en_in     (smram_high_alias_enable),
    .top_en_in      (top_smm_segment_enable),
    .top_size_in    (top_smm_segment_size),
    .active_out     (smm_act),
    .compat_hit_out (c_hit),
    .high_hit_out   (h_hit),
    .top_hit_out    (t_hit)
  );

  legacy_attr_decode u_attr (
    .addr_in     (a),
    .write_in    (txn_in.write),
    .attr_in     (attr_r),
    .hit_out     (attr_hit),
    .to_dram_out (attr_dram)
  );

  assign visible   = txn_in.smm | smram_open;
  assign smm_dram  = visible & (c_hit | h_hit | t_hit);
  // Hidden top segment must not leak DRAM contents
  assign smm_block = t_hit & ~visible;

  assign dos        = (a <= `DOS_END);
  assign isa        = in_rng(a, `ISA_LO, `ISA_HI);
  assign vga        = in_rng(a, `VGA_LO, `VGA_HI);
  // 15 MB hole, APIC block, firmware
  assign hole15     = hole15_en & in_rng(a, `HOLE15_LO, `HOLE15_HI);
  assign apic       = in_rng(a, `APIC_LO, `APIC_HI);
  assign hbios      = in_rng(a, `HBIOS_LO, `HBIOS_HI);
  assign below_top_of_low_dram = (a < top_of_low_dram_addr);
  assign above4     = (a >= `FOUR_GB);
  // reclaimed DRAM window above 4 GB
  assign reclaim    = above4 && ({1'b0, a} < reclaim_top);

  assign tgt_nxt =
    smm_dram   ? TGT_DRAM :
    smm_block  ? TGT_PCI :
    apic       ? TGT_IOAPIC :
    hbios      ? TGT_PCI :
    dos        ? TGT_DRAM :
    isa        ? (isa_to_dram ? TGT_DRAM : TGT_PCI) :
    vga        ? TGT_PCI :
    attr_hit   ? (attr_dram ? TGT_DRAM : TGT_PCI) :
    hole15     ? TGT_PCI :
    below_top_of_low_dram ? TGT_DRAM :
    reclaim    ? TGT_DRAM :
                 TGT_PCI;

  assign xlate = (visible && h_hit) ? (a - `HIGH_SMM_SEGMENT_LO + `VGA_LO) :
                 reclaim            ? (a - gap) :
                                      a;

  assign route_nxt = {tgt_nxt, xlate};

  ////////////////////////////////////////////////////////////////////////
  // Route answer, one cycle after the transaction

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      route_valid_r <= 1'b0;
      route_r       <= '0;
    end else if (ce_in) begin
      route_valid_r <= txn_valid_in;
      if (txn_valid_in) begin
        route_r <= route_nxt;
      end
    end
  end

  // Transaction count and last target for status
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      count_r    <= 16'h0000;
      last_tgt_r <= TGT_DRAM;
    end else if (take) begin
      count_r    <= count_r + 16'h0001;
      last_tgt_r <= tgt_nxt;
    end
  end

  assign route_valid_out = route_valid_r;
  assign route_out       = route_r;

  ////////////////////////////////////////////////////////////////////////
  // Register port

  assign wr = ce_in & reg_we_in;

  // Writes; unmapped offsets are ignored
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl_r <= `CTRL_RST;
      attr_r <= `ATTR_RST;
      top_of_low_dram_r <= `TOP_OF_LOW_DRAM_RST;
      tom_r  <= `TOM_RST;
    end else if (wr) begin
      case (reg_addr_in)
        `REG_CTRL: ctrl_r <= reg_wdata_in[`CTRL_W-1:0];
        `REG_ATTR: attr_r <= reg_wdata_in[`ATTR_W-1:0];
        `REG_TOP_OF_LOW_DRAM: top_of_low_dram_r <= reg_wdata_in[15:0];
        `REG_TOM:  tom_r  <= reg_wdata_in[19:0];
        default: ;
      endcase
    end
  end

  assign stat_word = {count_r, 8'h00, 2'h0, last_tgt_r, 1'b0, smm_act};

  // Read select; unmapped offsets read zero
  assign rd_mux = (reg_addr_in == `REG_CTRL) ? {24'h00_0000, ctrl_r} :
                  (reg_addr_in == `REG_ATTR) ? {6'h00, attr_r} :
                  (reg_addr_in == `REG_TOP_OF_LOW_DRAM) ? {16'h0000, top_of_low_dram_r} :
                  (reg_addr_in == `REG_TOM)  ? {12'h000, tom_r} :
                  (reg_addr_in == `REG_STAT) ? stat_word :
                                               32'h0000_0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce_in) begin
      rdata_r <= reg_re_in ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  answer_next_a: assert property (
    take |=> route_valid_r)
    else $error("transaction got no route answer");

  dos_dram_a: assert property (
    take && !smm_dram && !smm_block && (a <= `DOS_END)
    |=> route_r.target == TGT_DRAM && route_r.dram_addr == $past(a))
    else $error("low 512 KB not sent to DRAM");

  isa_window_a: assert property (
    take && !smm_dram && !smm_block && in_rng(a, `ISA_LO, `ISA_HI)
    |=> route_r.target == ($past(isa_to_dram) ? TGT_DRAM : TGT_PCI))
    else $error("ISA window routed against control");

  vga_pci_a: assert property (
    take && !smm_dram && in_rng(a, `VGA_LO, `VGA_HI)
    |=> route_r.target == TGT_PCI)
    else $error("graphics window not sent to PCI");

  attr_route_a: assert property (
    take && !smm_dram && !smm_block && attr_hit
    |=> route_r.target == ($past(attr_dram) ? TGT_DRAM : TGT_PCI))
    else $error("segment attribute not applied");

  sysbios_read_a: assert property (
    take && !smm_dram && !smm_block && !txn_in.write &&
    in_rng(a, 36'h0_000f_0000, `ATTR_HI) && !attr_r[`F_RD_IDX]
    |=> route_r.target == TGT_PCI)
    else $error("system block read reached DRAM while disabled");

  ro_shadow_a: assert property (
    take && !smm_dram && !smm_block && txn_in.write &&
    in_rng(a, 36'h0_000f_0000, `ATTR_HI) && !attr_r[`F_WR_IDX]
    |=> route_r.target == TGT_PCI)
    else $error("write to read-only shadow reached DRAM");

  hole15_a: assert property (
    take && hole15_en && !smm_dram && in_rng(a, `HOLE15_LO, `HOLE15_HI)
    |=> route_r.target == TGT_PCI)
    else $error("15 MB hole not sent to PCI");

  pci_above_a: assert property (
    take && !smm_dram && (a >= top_of_low_dram_addr) && (a >= `MEG1) && (a < `APIC_LO)
    |=> route_r.target == TGT_PCI)
    else $error("address above low DRAM reached DRAM");

  hbios_pci_a: assert property (
    take && in_rng(a, `HBIOS_LO, `HBIOS_HI)
    |=> route_r.target == TGT_PCI)
    else $error("firmware range not sent to PCI");

  apic_block_a: assert property (
    take && in_rng(a, `APIC_LO, `APIC_HI)
    |=> route_r.target == TGT_IOAPIC)
    else $error("interrupt-controller block misrouted");

  reclaim_a: assert property (
    take && above4 && ({1'b0, a} < reclaim_top)
    |=> route_r.target == TGT_DRAM &&
        route_r.dram_addr == $past(a) - `FOUR_GB + $past(top_of_low_dram_addr))
    else $error("reclaimed DRAM address wrong");

  top_smm_segment_hidden_a: assert property (
    take && t_hit && !txn_in.smm && !smram_open
    |=> route_r.target == TGT_PCI)
    else $error("top segment visible outside management mode");

  high_sel_a: assert property (
    wr && (reg_addr_in == `REG_CTRL) &&
    reg_wdata_in[`CTRL_GLB] && reg_wdata_in[`CTRL_HIGH]
    |=> smm_act.h && !smm_act.c)
    else $error("high enable did not replace compatible segment");

  compat_dram_a: assert property (
    take && c_hit && txn_in.smm
    |=> route_r.target == TGT_DRAM && route_r.dram_addr == $past(a))
    else $error("compatible segment not sent to DRAM");

  high_smm_segment_xlate_a: assert property (
    take && h_hit && txn_in.smm
    |=> route_r.target == TGT_DRAM &&
        route_r.dram_addr == $past(a) - `HIGH_SMM_SEGMENT_LO + `VGA_LO)
    else $error("high segment translation wrong");

  top_smm_segment_same_a: assert property (
    take && t_hit && txn_in.smm
    |=> route_r.target == TGT_DRAM && route_r.dram_addr == $past(a))
    else $error("top segment address moved");

endmodule // host_memory_address_decoder

`default_nettype wire

// ==== src/legacy_attr_decode.sv ====
/*
  Legacy segment attribute lookup for 0C0000h to 0FFFFFh.
  Assumes the caller gives this result lower priority than management RAM.
*/
`timescale 1ns/1ps
`default_nettype none
`include "decoder_defs.svh"

module legacy_attr_decode
  import decoder_pkg::*;
(
  input  wire logic [`ADDR_W-1:0] addr_in,
  input  wire logic               write_in,
  input  wire logic [`ATTR_W-1:0] attr_in,
  output logic                    hit_out,
  output logic                    to_dram_out
);

  logic [3:0] seg;

  assign hit_out = in_rng(addr_in, `ATTR_LO, `ATTR_HI);
  // eight add-in and four extended blocks, one system block
  assign seg = (addr_in[17:16] == 2'h3) ? `F_SEG : addr_in[17:14];
  assign to_dram_out = write_in ? attr_in[{seg, `ATTR_WR}] : attr_in[{seg, `ATTR_RD}];

endmodule // legacy_attr_decode

`default_nettype wire

// ==== src/smm_space_decode.sv ====
/*
  Management RAM segment enables and address hits.
  Assumes the caller applies visibility (management mode or open).
*/
`timescale 1ns/1ps
`default_nettype none
`include "decoder_defs.svh"

module smm_space_decode
  import decoder_pkg::*;
(
  input  wire logic [`ADDR_W-1:0] addr_in,
  input  wire logic [`ADDR_W-1:0] top_of_low_dram_addr_in,
  input  wire logic               global_en_in,
  input  wire logic               high_en_in,
  input  wire logic               top_en_in,
  input  wire logic [1:0]         top_size_in,
  output var  smm_act_type        active_out,
  output logic                    compat_hit_out,
  output logic                    high_hit_out,
  output logic                    top_hit_out
);

  logic [`ADDR_W-1:0] top_size;
  logic [`ADDR_W-1:0] top_base;

  assign active_out = {global_en_in & ~high_en_in,
                       global_en_in & high_en_in,
                       global_en_in & top_en_in};

  // Top segment sits just under the top of low DRAM, 128 KB to 1 MB
  assign top_size = `TOP_SMM_SEGMENT_UNIT << top_size_in;
  assign top_base = top_of_low_dram_addr_in - top_size;

  assign compat_hit_out = active_out.c && in_rng(addr_in, `VGA_LO, `VGA_HI);
  assign high_hit_out = active_out.h && in_rng(addr_in, `HIGH_SMM_SEGMENT_LO, `HIGH_SMM_SEGMENT_HI);
  assign top_hit_out = active_out.t && (top_of_low_dram_addr_in >= top_size) &&
                       (addr_in >= top_base) && (addr_in < top_of_low_dram_addr_in);

endmodule // smm_space_decode

`default_nettype wire
